/* logic/plc_arith_defs.vh */
// Purpose: shared constants of the arithmetic unit and its bus slave
// Assumes: byte addresses on a 32-bit AHB-Lite slave, one word per register
// Notes: offsets are compared against haddr[7:0]
`ifndef PLC_ARITH_DEFS_VH
`define PLC_ARITH_DEFS_VH

`define OFF_OPERAND_A 8'h00
`define OFF_OPERAND_B 8'h04
`define OFF_CONTROL 8'h08
`define OFF_RESULT 8'h0c
`define OFF_FLAGS 8'h10
`define OFF_IRQ_STATUS 8'h14
`define OFF_IRQ_CLEAR 8'h18
`define OFF_IRQ_ENABLE 8'h1c

// control word fields
`define CTL_OP_LSB 0
`define CTL_TYPE_LSB 2
`define CTL_START_BIT 4
`define CTL_POWER_BIT 5
`define CTL_FAULT_BIT 6

// operation codes
`define OP_ADD 2'h0
`define OP_SUB 2'h1
`define OP_MUL 2'h2
`define OP_DIV 2'h3

// operand types
`define TYPE_INT 2'h0
`define TYPE_DINT 2'h1
`define TYPE_REAL 2'h2

// flag word fields
`define FLG_ZERO_BIT 0
`define FLG_OVF_BIT 1
`define FLG_NEG_BIT 2
`define FLG_DIVZ_BIT 3
`define FLG_BUSY_BIT 4
`define FLG_FLOW_BIT 5

// interrupt events
`define IRQ_DONE_BIT 0
`define IRQ_ERROR_BIT 1

// reset values
`define RST_WORD 32'h00000000
`define RST_FLAGS 4'h0
`define RST_IRQ 2'h0

// real format
`define EXP_MAX 8'hff
`define EXP_BIAS 10'h07f

`endif

/* logic/plc_arith_unit.v */
// Purpose: integer, double-integer and real add/sub/mul/div with status flags
// Assumes: single clock, AHB-Lite slave, single word transfers
// Notes: reals round toward zero, subnormals flush to zero
`include "plc_arith_defs.vh"
module plc_arith_unit #(
   parameter DIV_NUM_W = 49
) (
   input wire clock, // 200 MHz processor clock
   input wire reset, // async, active high
   input wire hsel, // slave select
   input wire [31:0] haddr, // byte address
   input wire [1:0] htrans, // transfer type
   input wire hwrite, // write when high
   input wire [2:0] hsize, // only word writes accepted; reads ignore size
   input wire [31:0] hwdata, // write data
   input wire hready, // bus ready
   output wire hreadyout, // slave ready
   output wire hresp, // always OKAY
   output reg [31:0] hrdata, // read data
   output reg flow_enable_out, // power flow after the last operation
   output wire irq // level interrupt
);
   localparam ST_IDLE = 2'h0;
   localparam ST_EXEC = 2'h1;
   localparam ST_WAIT = 2'h2;

   reg [31:0] opA_r, opB_r, result_r;
   reg [1:0] opCode_r, opType_r, state_r;
   reg power_r, fault_r;
   reg zero_flag, overflow_flag, negative_flag, divide_by_zero_flag;
   reg [1:0] irqStat_r, irqEn_r;
   reg [7:0] addr_r;
   reg wrPend_r, rdPend_r;

   // true when v holds a signed value of 16 (w32=0) or 32 bits
   function fits;
      input [63:0] v;
      input w32;
      begin
         if (w32)
            fits = (v[63:31] == {33{1'b0}}) || (v[63:31] == {33{1'b1}});
         else
            fits = (v[63:15] == {49{1'b0}}) || (v[63:15] == {49{1'b1}});
      end
   endfunction

   // leading zero count of a 28-bit mantissa sum
   function [4:0] lead28;
      input [27:0] v;
      integer i;
      begin
         lead28 = 5'd0;
         for (i = 0; i < 28; i = i + 1)
            if (v[i])
               lead28 = 5'd27 - i[4:0];
      end
   endfunction

   // bus slave: writes land in the data phase, reads take one wait state
   wire addrPhase = hsel && hready && htrans[1];
   assign hreadyout = ~rdPend_r;
   assign hresp = 1'b0;
   wire wrEn = wrPend_r;
   wire busy = (state_r != ST_IDLE);
   wire startReq = wrEn && (addr_r == `OFF_CONTROL) && hwdata[`CTL_START_BIT] && !busy;

   // operand views
   wire isInt = (opType_r == `TYPE_INT);
   wire isReal = (opType_r == `TYPE_REAL);
   wire w32 = ~isInt;
   wire [31:0] sa = isInt ? {{16{opA_r[15]}}, opA_r[15:0]} : opA_r;
   wire [31:0] sb = isInt ? {{16{opB_r[15]}}, opB_r[15:0]} : opB_r;
   wire [63:0] sa64 = {{32{sa[31]}}, sa};
   wire [63:0] sb64 = {{32{sb[31]}}, sb};
   wire [63:0] intSum = (opCode_r == `OP_SUB) ? (sa64 - sb64) : (sa64 + sb64);
   wire signed [63:0] intProd = $signed(sa64) * $signed(sb64);
   wire [31:0] magA = sa[31] ? (32'h0 - sa) : sa;
   wire [31:0] magB = sb[31] ? (32'h0 - sb) : sb;

   // real unpacking, zero exponent taken as zero
   wire [7:0] ea = opA_r[30:23];
   wire [7:0] eb = opB_r[30:23];
   wire [23:0] ma = {(ea != 8'h00), opA_r[22:0]};
   wire [23:0] mb = {(eb != 8'h00), opB_r[22:0]};
   wire zeroA = (ea == 8'h00);
   wire zeroB = (eb == 8'h00);
   wire realBad = (ea == `EXP_MAX) || (eb == `EXP_MAX);
   wire signB = opB_r[31] ^ (opCode_r == `OP_SUB);

   wire divZero = isReal ? zeroB : (sb == 32'h0);

   // divider shared by all three types
   wire [DIV_NUM_W-1:0] divNum = isReal ? {ma, 25'h0} : {{(DIV_NUM_W-32){1'b0}}, magA};
   wire [31:0] divDen = isReal ? {8'h00, mb} : magB;
   wire [DIV_NUM_W-1:0] divQ;
   wire divDone;
   wire divStart = (state_r == ST_EXEC) && (opCode_r == `OP_DIV) && power_r && !fault_r
      && !divZero && !(isReal && realBad);

   seq_divider #(.NUM_W(DIV_NUM_W), .DEN_W(32)) i_seq_divider (
      .clock(clock),
      .reset(reset),
      .start(divStart),
      .dividend(divNum),
      .divisor(divDen),
      .quotient(divQ),
      .done(divDone)
   );

   reg [31:0] resVal, fpRes;
   reg resOvf, fpOvf, swap, resZero, resNeg;
   reg [7:0] eBig, eSm, shAmt;
   reg [23:0] mBig, mSm;
   reg [26:0] smAl;
   reg [27:0] sum28, norm28;
   reg [4:0] lz;
   reg [9:0] eRes;
   reg [47:0] fProd;
   reg [63:0] intQ;
   reg [22:0] mRes;
   reg sRes, fpZero;

   // real datapath, truncating
   always @*
   begin
      swap = ({ea, ma} < {eb, mb});
      eBig = swap ? eb : ea;
      eSm = swap ? ea : eb;
      mBig = swap ? mb : ma;
      mSm = swap ? ma : mb;
      shAmt = eBig - eSm;
      smAl = (shAmt > 8'd26) ? 27'h0 : ({mSm, 3'b000} >> shAmt);
      sum28 = 28'h0;
      norm28 = 28'h0;
      lz = 5'd0;
      fProd = 48'h0;
      eRes = 10'h0;
      mRes = 23'h0;
      sRes = 1'b0;
      fpZero = 1'b0;
      case (opCode_r)
         `OP_ADD, `OP_SUB:
         begin
            sRes = swap ? signB : opA_r[31];
            if (opA_r[31] == signB)
               sum28 = {1'b0, mBig, 3'b000} + {1'b0, smAl};
            else
               sum28 = {1'b0, mBig, 3'b000} - {1'b0, smAl};
            lz = lead28(sum28);
            norm28 = sum28 << lz;
            eRes = {2'b00, eBig} + 10'd1 - {5'h00, lz};
            mRes = norm28[26:4];
            fpZero = (sum28 == 28'h0) || (zeroA && zeroB);
         end
         `OP_MUL:
         begin
            sRes = opA_r[31] ^ opB_r[31];
            fProd = ma * mb;
            eRes = {2'b00, ea} + {2'b00, eb} - `EXP_BIAS + {9'h000, fProd[47]};
            mRes = fProd[47] ? fProd[46:24] : fProd[45:23];
            fpZero = zeroA || zeroB;
         end
         default:
         begin
            sRes = opA_r[31] ^ opB_r[31];
            eRes = {2'b00, ea} - {2'b00, eb} + `EXP_BIAS - {9'h000, ~divQ[25]};
            mRes = divQ[25] ? divQ[24:2] : divQ[23:1];
            fpZero = zeroA;
         end
      endcase
      fpOvf = realBad || (!fpZero && !eRes[9] && (eRes[8:0] >= 9'd255));
      if (fpZero || eRes[9] || (eRes == 10'h0))
         fpRes = {sRes & ~fpZero, 31'h0};
      else
         fpRes = {sRes, eRes[7:0], mRes};
   end

   // result selection and flag derivation
   always @*
   begin
      intQ = (sa[31] ^ sb[31]) ? (64'h0 - {32'h0, divQ[31:0]}) : {32'h0, divQ[31:0]};
      resVal = 32'h0;
      resOvf = 1'b0;
      if (isReal)
      begin
         resVal = fpRes;
         resOvf = fpOvf;
      end
      else
      begin
         case (opCode_r)
            `OP_ADD, `OP_SUB:
            begin
               resVal = intSum[31:0];
               resOvf = !fits(intSum, w32);
            end
            `OP_MUL:
            begin
               resVal = intProd[31:0];
               resOvf = !fits(intProd, w32);
            end
            default:
            begin
               resVal = intQ[31:0];
               resOvf = !fits(intQ, w32);
            end
         endcase
         if (isInt)
            resVal = {16'h0000, resVal[15:0]};
      end
      if (isReal)
      begin
         resZero = (resVal[30:0] == 31'h0);
         resNeg = resVal[31] && !resZero;
      end
      else if (isInt)
      begin
         resZero = (resVal[15:0] == 16'h0000);
         resNeg = resVal[15];
      end
      else
      begin
         resZero = (resVal == 32'h0);
         resNeg = resVal[31];
      end
   end

   wire inExec = (state_r == ST_EXEC);
   wire endIdle = inExec && (!power_r || fault_r);
   wire endDivZ = inExec && power_r && !fault_r && (opCode_r == `OP_DIV) && divZero;
   wire endBad = inExec && power_r && !fault_r && isReal && realBad;
   wire commit = (inExec && power_r && !fault_r && !endDivZ && !endBad
      && (opCode_r != `OP_DIV)) || ((state_r == ST_WAIT) && divDone);
   wire opDone = endIdle || endDivZ || endBad || commit;
   wire opError = (inExec && fault_r && power_r) || endDivZ || endBad || (commit && resOvf);

   // sequencing, operands, result and flags
   always @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         state_r <= ST_IDLE;
         opA_r <= `RST_WORD;
         opB_r <= `RST_WORD;
         result_r <= `RST_WORD;
         opCode_r <= `OP_ADD;
         opType_r <= `TYPE_INT;
         power_r <= 1'b0;
         fault_r <= 1'b0;
         {divide_by_zero_flag, negative_flag, overflow_flag, zero_flag} <= `RST_FLAGS;
         flow_enable_out <= 1'b0;
      end
      else
      begin
         // operands cannot be rewritten mid-operation
         if (wrEn && !busy && (addr_r == `OFF_OPERAND_A))
            opA_r <= hwdata;
         if (wrEn && !busy && (addr_r == `OFF_OPERAND_B))
            opB_r <= hwdata;
         case (state_r)
            ST_IDLE:
            begin
               if (startReq)
               begin
                  opCode_r <= hwdata[`CTL_OP_LSB+1:`CTL_OP_LSB];
                  opType_r <= hwdata[`CTL_TYPE_LSB+1:`CTL_TYPE_LSB];
                  power_r <= hwdata[`CTL_POWER_BIT];
                  fault_r <= hwdata[`CTL_FAULT_BIT];
                  state_r <= ST_EXEC;
               end
            end
            ST_EXEC:
            begin
               if (!power_r)
               begin
                  flow_enable_out <= 1'b0;
                  state_r <= ST_IDLE;
               end
               else if (fault_r)
               begin
                  flow_enable_out <= 1'b0;
                  state_r <= ST_IDLE;
               end
               else if (endDivZ)
               begin
                  divide_by_zero_flag <= 1'b1;
                  flow_enable_out <= 1'b0;
                  state_r <= ST_IDLE;
               end
               else if (endBad)
               begin
                  overflow_flag <= 1'b1;
                  divide_by_zero_flag <= 1'b0;
                  flow_enable_out <= 1'b0;
                  state_r <= ST_IDLE;
               end
               else if (opCode_r == `OP_DIV)
                  state_r <= ST_WAIT;
               else
                  state_r <= ST_IDLE;
            end
            ST_WAIT:
            begin
               if (divDone)
                  state_r <= ST_IDLE;
            end
            default:
               state_r <= ST_IDLE;
         endcase
         if (commit)
         begin
            divide_by_zero_flag <= 1'b0;
            overflow_flag <= resOvf;
            flow_enable_out <= !resOvf;
            // result, zero and negative hold on overflow
            if (!resOvf)
            begin
               result_r <= resVal;
               zero_flag <= resZero;
               negative_flag <= resNeg;
            end
         end
      end
   end

   // interrupt status: a new event wins over a clear in the same cycle
   wire [1:0] irqSet = {opError, opDone};
   wire [1:0] irqClr = (wrEn && (addr_r == `OFF_IRQ_CLEAR)) ? hwdata[1:0] : 2'b00;
   assign irq = |(irqStat_r & irqEn_r);

   always @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         irqStat_r <= `RST_IRQ;
         irqEn_r <= `RST_IRQ;
         addr_r <= 8'h00;
         wrPend_r <= 1'b0;
         rdPend_r <= 1'b0;
         hrdata <= `RST_WORD;
      end
      else
      begin
         irqStat_r <= (irqStat_r & ~irqClr) | irqSet;
         if (wrEn && (addr_r == `OFF_IRQ_ENABLE))
            irqEn_r <= hwdata[1:0];
         if (hready)
         begin
            wrPend_r <= addrPhase && hwrite && (hsize == 3'h2);
            rdPend_r <= addrPhase && !hwrite;
            if (addrPhase)
               addr_r <= haddr[7:0];
         end
         else
            rdPend_r <= 1'b0;
         if (rdPend_r)
         begin
            case (addr_r)
               `OFF_OPERAND_A: hrdata <= opA_r;
               `OFF_OPERAND_B: hrdata <= opB_r;
               `OFF_CONTROL: hrdata <= {25'h0, fault_r, power_r, 1'b0, opType_r, opCode_r};
               `OFF_RESULT: hrdata <= result_r;
               `OFF_FLAGS: hrdata <= {26'h0, flow_enable_out, busy, divide_by_zero_flag,
                  negative_flag, overflow_flag, zero_flag};
               `OFF_IRQ_STATUS: hrdata <= {30'h0, irqStat_r};
               `OFF_IRQ_ENABLE: hrdata <= {30'h0, irqEn_r};
               default: hrdata <= 32'h0;
            endcase
         end
      end
   end
endmodule

/* logic/seq_divider.v */
// Purpose: unsigned restoring divider, one quotient bit per clock
// Assumes: start is a one-cycle pulse; inputs are taken at start
// Notes: takes NUM_W cycles; remainder is dropped on purpose
module seq_divider #(
   parameter NUM_W = 49,
   parameter DEN_W = 32
) (
   input wire clock, // processor clock
   input wire reset, // async, active high
   input wire start, // pulse: begin a division
   input wire [NUM_W-1:0] dividend, // unsigned numerator
   input wire [DEN_W-1:0] divisor, // unsigned, nonzero
   output reg [NUM_W-1:0] quotient, // quotient, valid with done
   output reg done // pulse: quotient ready
);
   reg [DEN_W:0] rem_r;
   reg [DEN_W-1:0] den_r;
   reg [7:0] count_r;
   reg run_r;
   wire [DEN_W:0] remSh = {rem_r[DEN_W-1:0], quotient[NUM_W-1]};
   wire take = (remSh >= {1'b0, den_r});

   always @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         rem_r <= {(DEN_W+1){1'b0}};
         den_r <= {DEN_W{1'b0}};
         quotient <= {NUM_W{1'b0}};
         count_r <= 8'h00;
         run_r <= 1'b0;
         done <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         if (start)
         begin
            rem_r <= {(DEN_W+1){1'b0}};
            den_r <= divisor;
            quotient <= dividend;
            count_r <= NUM_W[7:0];
            run_r <= 1'b1;
         end
         else if (run_r)
         begin
            rem_r <= take ? (remSh - {1'b0, den_r}) : remSh;
            quotient <= {quotient[NUM_W-2:0], take};
            count_r <= count_r - 8'h01;
            if (count_r == 8'h01)
            begin
               run_r <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end
endmodule

/* verification/ahb_sequencer_model.sv */
// Purpose: bus master standing in for the instruction sequencer
// Assumes: one slave whose hreadyout is the bus hready
// Notes: every wait is bounded; an expired wait is counted in timeouts
module ahb_sequencer_model (
   input logic clock, // processor clock
   input logic hready, // bus ready
   input logic [31:0] hrdata, // read data
   output logic hsel, // slave select
   output logic [31:0] haddr, // byte address
   output logic [1:0] htrans, // transfer type
   output logic hwrite, // write when high
   output logic [2:0] hsize, // always a word
   output logic [31:0] hwdata // write data
);
   timeunit 1ns;
   timeprecision 1ps;
   integer timeouts;
   initial
   begin
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      timeouts = 0;
   end
   task waitReady;
      integer n;
   begin
      n = 0;
      @(posedge clock);
      while (!hready && n < 64)
      begin
         @(posedge clock);
         n = n + 1;
      end
      if (!hready)
         timeouts = timeouts + 1;
   end
   endtask
   task busWrite(input logic [7:0] a, input logic [31:0] d);
   begin
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= 1'b1;
      waitReady;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      waitReady;
      // released data must not look like a fresh copy of the last word
      hwdata <= ~d;
   end
   endtask
   task busRead(input logic [7:0] a, output logic [31:0] d);
   begin
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= 1'b0;
      waitReady;
      hsel <= 1'b0;
      htrans <= 2'h0;
      waitReady;
      d = hrdata;
   end
   endtask
endmodule

/* verification/plc_arith_unit_properties.sv */
// Purpose: port-level checks of the arithmetic unit
// Assumes: no start is written while an operation runs
// Notes: operand mirrors follow bus writes, so expectations need no internals
`include "plc_arith_defs.vh"
module plc_arith_unit_properties (
   input logic clock, // processor clock
   input logic reset, // async, active high
   input logic hsel, // slave select
   input logic [31:0] haddr, // byte address
   input logic [1:0] htrans, // transfer type
   input logic hwrite, // write when high
   input logic [31:0] hwdata, // write data
   input logic hready, // bus ready
   input logic hreadyout, // slave ready
   input logic hresp, // response
   input logic flow_enable_out, // power flow out
   input logic irq // interrupt level
);
   reg dPh, dWr;
   reg [7:0] dAddr;
   reg [31:0] opA, opB;
   reg [6:0] ctlR;
   wire wrEdge = dPh & dWr & hready;
   wire startEdge = wrEdge & (dAddr == `OFF_CONTROL) & hwdata[4];
   wire calc = hwdata[5] & ~hwdata[6];
   wire [16:0] a16 = {opA[15], opA[15:0]};
   wire [16:0] b16 = {opB[15], opB[15:0]};
   wire [16:0] s16 = ctlR[0] ? a16 - b16 : a16 + b16;
   wire [32:0] s32 = ctlR[0] ? {opA[31], opA} - {opB[31], opB} : {opA[31], opA} + {opB[31], opB};
   wire bZero = (hwdata[3:2] == 2'h0) ? (opB[15:0] == 16'h0000) : (opB == 32'h00000000);
   wire divOvf = (opA == 32'h80000000) && (opB == 32'hffffffff);
   always @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         dPh <= 1'b0;
         dWr <= 1'b0;
         dAddr <= 8'h00;
         opA <= 32'h00000000;
         opB <= 32'h00000000;
         ctlR <= 7'h00;
      end
      else
      begin
         if (hready)
         begin
            dPh <= hsel & htrans[1];
            dWr <= hwrite;
            dAddr <= haddr[7:0];
         end
         if (wrEdge && dAddr == `OFF_OPERAND_A)
            opA <= hwdata;
         if (wrEdge && dAddr == `OFF_OPERAND_B)
            opB <= hwdata;
         if (startEdge)
            ctlR <= hwdata[6:0];
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   chk_resp_okay: assert property (hresp == 1'b0)
      else $error("slave gave a non-okay response");
   chk_read_wait: assert property (hready && hsel && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read did not take exactly one wait state");
   chk_write_nowait: assert property (hready && hsel && htrans[1] && hwrite |=> hreadyout)
      else $error("write data phase was stretched");
   chk_flow_blocked: assert property (startEdge && !calc |-> ##3 !flow_enable_out)
      else $error("flow stayed on without power or with a fault");
   chk_flow_divzero: assert property (
      startEdge && calc && hwdata[1:0] == 2'h3 && !hwdata[3] && bZero |-> ##3 !flow_enable_out)
      else $error("zero divisor left flow on");
   chk_int_overflow: assert property (
      startEdge && calc && hwdata[3:1] == 3'h0 |-> ##3 flow_enable_out == (s16[16] == s16[15]))
      else $error("integer add or subtract flow wrong");
   chk_dint_overflow: assert property (
      startEdge && calc && hwdata[3:1] == 3'h2 |-> ##3 flow_enable_out == (s32[32] == s32[31]))
      else $error("double add or subtract flow wrong");
   chk_div_latency: assert property (
      startEdge && calc && hwdata[3:0] == 4'h7 && !bZero && !divOvf
      |-> ##51 flow_enable_out == $past(flow_enable_out, 50) ##1 flow_enable_out)
      else $error("double divide finished at the wrong time");
   cover property (startEdge && hwdata[1:0] == 2'h3);
   cover property ($fell(flow_enable_out));
   cover property (irq ##1 !irq);
endmodule
bind plc_arith_unit plc_arith_unit_properties i_plc_arith_unit_properties (.clock(clock),
   .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .flow_enable_out(flow_enable_out), .irq(irq));

/* verification/plc_arith_unit_test.sv */
// Purpose: self-checking bench for the arithmetic unit
// Assumes: one bus master, word transfers only
// Notes: a row is {control, operand a, operand b, result, flags}; failed ops keep old result
`include "plc_arith_defs.vh"
module plc_arith_unit_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock, reset, hsel, hwrite, hreadyout, hresp, flow_enable_out, irq;
   logic [31:0] haddr, hwdata, hrdata, v;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [111:0] tv [0:17];
   integer failures, n_tests, i, n;
   plc_arith_unit i_plc_arith_unit (.clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .flow_enable_out(flow_enable_out), .irq(irq));
   ahb_sequencer_model i_ahb_sequencer_model (.clock(clock), .hready(hreadyout),
      .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata));
   initial
   begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   task check(input logic [31:0] got, input logic [31:0] exp);
   begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
         failures = failures + 1;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   end
   endtask
   task rd(input logic [7:0] a, input logic [31:0] exp);
   begin
      i_ahb_sequencer_model.busRead(a, v);
      check(v, exp);
      // an expired bus wait ends the run; final_report counts it
      if (i_ahb_sequencer_model.timeouts != 0)
         final_report;
   end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
   begin
      i_ahb_sequencer_model.busWrite(a, d);
      if (i_ahb_sequencer_model.timeouts != 0)
         final_report;
   end
   endtask
   task final_report;
   begin
      failures = failures + i_ahb_sequencer_model.timeouts;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   end
   endtask
   initial
   begin
      failures = 0;
      n_tests = 0;
      reset = 1'b1;
      tv[0] = 112'h30_00007fff_00000001_00000000_02;
      tv[1] = 112'h31_00000005_00000007_0000fffe_24;
      tv[2] = 112'h32_00000100_00000100_0000fffe_06;
      tv[3] = 112'h33_0000fff9_00000002_0000fffd_24;
      tv[4] = 112'h33_00000005_00000000_0000fffd_0c;
      tv[5] = 112'h34_7fffffff_00000001_0000fffd_06;
      tv[6] = 112'h35_00000003_00000003_00000000_21;
      tv[7] = 112'h36_00010000_00010000_00000000_03;
      tv[8] = 112'h37_ffffff9c_00000007_fffffff2_24;
      tv[9] = 112'h38_3fc00000_40100000_40700000_20;
      tv[10] = 112'h39_3f800000_3f800000_00000000_21;
      tv[11] = 112'h3a_c0000000_40400000_c0c00000_24;
      tv[12] = 112'h3b_40c00000_40000000_40400000_20;
      tv[13] = 112'h38_7f800000_3f800000_40400000_02;
      tv[14] = 112'h10_00000001_00000001_40400000_02;
      tv[15] = 112'h70_00000001_00000001_40400000_02;
      tv[16] = 112'h3b_3f800000_00000000_40400000_0a;
      tv[17] = 112'h33_00008000_0000ffff_40400000_02;
      repeat (12) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      for (i = 0; i < 8; i = i + 1)
         rd(8'(i * 4), 32'h00000000);
      wr(`OFF_RESULT, 32'hffffffff);
      rd(`OFF_RESULT, 32'h00000000);
      rd(8'h40, 32'h00000000);
      for (i = 0; i < 18; i = i + 1)
      begin
         wr(`OFF_OPERAND_A, tv[i][103:72]);
         wr(`OFF_OPERAND_B, tv[i][71:40]);
         wr(`OFF_CONTROL, {24'h000000, tv[i][111:104]});
         v = 32'h00000010;
         // operands stay put until busy drops
         for (n = 0; n < 40 && v[4]; n = n + 1)
            i_ahb_sequencer_model.busRead(`OFF_FLAGS, v);
         check({31'h0, v[4]}, 32'h00000000);
         // a unit that never leaves busy ends the run
         if (v[4])
            final_report;
         rd(`OFF_FLAGS, {24'h000000, tv[i][7:0]});
         rd(`OFF_RESULT, tv[i][39:8]);
         rd(`OFF_OPERAND_A, tv[i][103:72]);
         check({31'h0, flow_enable_out}, {31'h0, tv[i][5]});
         if (i == 0)
         begin
            check({31'h0, irq}, 32'h00000000);
            wr(`OFF_IRQ_ENABLE, 32'h00000003);
            rd(`OFF_IRQ_ENABLE, 32'h00000003);
         end
         @(posedge clock);
         check({31'h0, irq}, 32'h00000001);
         wr(`OFF_IRQ_CLEAR, 32'h00000003);
         @(posedge clock);
         check({31'h0, irq}, 32'h00000000);
      end
      final_report;
   end
endmodule
